/* core/i2csb_pkg.sv */
// package of offsets, sizes and reset values for the sequence buffer config block
package i2csb_pkg;

   // ==========================================================================
   // sizes
   // ==========================================================================
   localparam int NUM_CH = 3;
   localparam int TXN_NUM = 64;
   localparam int BUF_DEPTH = 4352;
   localparam int PTR_W = 15;
   localparam int MEM_AW = 13;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 2 + PTR_W + 8;

   // ==========================================================================
   // register offsets, channel 0; later channels sit one stride higher
   // ==========================================================================
   localparam logic [7:0] REG_TXN_COUNT = 8'hc4;
   localparam logic [7:0] REG_DATA = 8'hc5;
   localparam logic [7:0] REG_SEL = 8'hc6;
   localparam logic [7:0] REG_OFS = 8'hc7;
   localparam logic [7:0] REG_BYTECNT = 8'hc8;
   localparam logic [7:0] CH_STRIDE = 8'h10;

   // register index within a channel window, relative to the count register
   localparam logic [3:0] IDX_COUNT = 4'h0;
   localparam logic [3:0] IDX_DATA = 4'h1;
   localparam logic [3:0] IDX_SEL = 4'h2;
   localparam logic [3:0] IDX_OFS = 4'h3;
   localparam logic [3:0] IDX_BYTECNT = 4'h4;

   // ==========================================================================
   // fields, limits and reset values
   // ==========================================================================
   localparam int SEL_MSB = 5;
   localparam logic [7:0] MAX_TXN_COUNT = 8'h40;
   localparam logic [6:0] CFG_LAST = 7'h40;
   localparam logic [7:0] BYTECNT_MAX = 8'hff;
   localparam logic [5:0] SEL_RST = 6'h00;
   localparam logic [7:0] OFS_RST = 8'h00;
   localparam logic [7:0] BYTECNT_RST = 8'h00;
   localparam logic [7:0] INVALID_RD = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // read pipeline source
   typedef enum logic [1:0] {
      RD_NONE = 2'b00,
      RD_REG = 2'b01,
      RD_MEM = 2'b10
   } i2csb_rd_t;

endpackage

/* core/i2csb_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module i2csb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic ready;
      logic valid;
   } i2csb_fifo_st_t;

   i2csb_fifo_st_t s_q;
   i2csb_fifo_st_t s_d;
   logic [WIDTH-1:0] store [DEPTH];
   logic push;
   logic pop;

   // ==========================================================================
   // pointer and flag update; flags are registered so ready comes from a flop
   // ==========================================================================
   always_comb begin
      s_d = s_q;
      push = in_valid_in & s_q.ready;
      pop = s_q.valid & out_ready_in;
      if (push) begin
         s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
      s_d.ready = (s_d.cnt != CW'(DEPTH));
      s_d.valid = (s_d.cnt != '0);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // storage has no reset; only slots below the count are ever read
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         store[s_q.wp] <= in_data_in;
      end
   end

   assign in_ready_out = s_q.ready;
   assign out_valid_out = s_q.valid;
   assign out_data_out = store[s_q.rp];

endmodule

/* core/i2csb_seq_cfg.sv */
// sequence configuration, buffer data port and byte counter for three channels
//
// Overview of operation
// - count register holds transactions, saturated at 40h
// - sixty-four eight-bit length entries per channel
// - engine runs only the counted transactions
// - zero count clears go bit, nothing else
// - zero length: skip read, write address only
// - data port auto-increments; writes only while idle
// - pointer from select and offset, reset 00h
// - rewind bit reloads pointer from select/offset
// - select 00h returns pointer to buffer start
// - writing select clears the byte offset
// - select uses bits 5:0, upper bits reserved
// - accesses continue from newly selected position
// - uninitialised selection outside buffer flags error
// - offset outside buffer flags error, drops data
// - byte offset is eight-bit zero-based index
// - pointer runs across transaction boundaries freely
// - data bits pass unchanged to bus levels
// - byte counter read-only, live, eight bits
// - count acked write bytes, all read bytes
// - byte counter cleared at every sequence start
// - engine read flag input selects read direction
`timescale 1ns/1ps
module i2csb_seq_cfg (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [7:0] host_addr_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [7:0] host_wdata_in,
   output logic [7:0] host_rdata_out,
   output logic host_rvalid_out,
   output logic host_wr_ready_out,
   input wire logic [2:0] chan_active_in,
   input wire logic [2:0] seq_go_in,
   input wire logic [2:0] ptr_rewind_in,
   output logic [2:0] seq_go_clear_out,
   output logic [2:0] seq_start_out,
   output logic [2:0] buf_err_set_out,
   input wire logic [1:0] eng_ch_in,
   input wire logic [5:0] eng_txn_idx_in,
   input wire logic eng_txn_read_in,
   input wire logic eng_byte_done_in,
   input wire logic eng_byte_acked_in,
   input wire logic eng_byte_is_read_in,
   input wire logic eng_mem_rd_in,
   input wire logic eng_mem_wr_in,
   input wire logic [14:0] eng_mem_addr_in,
   input wire logic [7:0] eng_mem_wdata_in,
   output logic [7:0] eng_mem_rdata_out,
   output logic [7:0] eng_txn_len_out,
   output logic eng_txn_skip_out,
   output logic eng_txn_addr_only_out,
   output logic eng_txn_last_out,
   output logic eng_txn_in_seq_out
);

   // ==========================================================================
   // state
   // ==========================================================================
   typedef struct packed {
      logic [2:0][7:0] cnt;
      logic [2:0][63:0][7:0] len;
      logic [2:0][5:0] sel;
      logic [2:0][7:0] ofs;
      logic [2:0][14:0] ptr;
      logic [2:0][6:0] cfg;
      logic [2:0][7:0] bcnt;
      logic [2:0] started;
      logic [2:0] go_clr;
      logic [2:0] start;
      logic [2:0] berr;
      i2csb_pkg::i2csb_rd_t rd_kind;
      logic rd_err;
      logic [7:0] rd_reg;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] tlen;
      logic tskip;
      logic taddr_only;
      logic tlast;
      logic tinseq;
   } i2csb_st_t;

   i2csb_st_t s_q;
   i2csb_st_t s_d;

   logic [7:0] mem [i2csb_pkg::NUM_CH][i2csb_pkg::BUF_DEPTH];
   logic [7:0] host_mem_q;
   logic [7:0] eng_rdata_q;

   logic [7:0] off;
   logic [1:0] hch;
   logic [1:0] mch;
   logic [3:0] hidx;
   logic hv;
   logic [14:0] hptr;
   logic herr;
   logic [5:0] new_sel;
   logic [7:0] elen;
   logic [1:0] ech;
   logic push_valid;
   logic push_ready;
   logic [i2csb_pkg::FIFO_W-1:0] push_data;
   logic drain_valid;
   logic drain_ready;
   logic [i2csb_pkg::FIFO_W-1:0] drain_data;
   logic [1:0] dch;
   logic [14:0] dptr;
   logic [7:0] dbyte;

   // start of a transaction's data: sum of the lengths stored before it
   function automatic logic [14:0] base_of(input logic [63:0][7:0] lens,
                                           input logic [5:0] sel);
      logic [14:0] acc;
      acc = '0;
      for (int i = 0; i < i2csb_pkg::TXN_NUM; i++) begin
         if (i < int'(sel)) begin
            acc = acc + 15'(lens[i]);
         end
      end
      return acc;
   endfunction

   // ==========================================================================
   // address decode
   // ==========================================================================
   // one window per channel, each a stride above the last
   always_comb begin
      off = host_addr_in - i2csb_pkg::REG_TXN_COUNT;
      hch = off[5:4];
      hidx = off[3:0];
      hv = (off[7:6] == 2'b00) && (hch != 2'b11) && (hidx <= i2csb_pkg::IDX_BYTECNT);
      mch = hv ? hch : 2'b00;
      hptr = s_q.ptr[mch];
      // anything past the channel buffer is an error access
      herr = (hptr >= 15'(i2csb_pkg::BUF_DEPTH));
      new_sel = host_wdata_in[i2csb_pkg::SEL_MSB:0]; // upper bits dropped
   end

   // ==========================================================================
   // main next-state logic
   // ==========================================================================
   always_comb begin
      s_d = s_q;
      s_d.go_clr = '0;
      s_d.start = '0;
      s_d.berr = '0;
      s_d.rd_kind = i2csb_pkg::RD_NONE;
      s_d.rd_err = 1'b0;
      s_d.rvalid = 1'b0;
      push_valid = 1'b0;
      push_data = '0;
      ech = (eng_ch_in == 2'b11) ? 2'b00 : eng_ch_in; // idle engine: keep index in range
      elen = s_q.len[ech][eng_txn_idx_in];

      // second read stage: registered memory byte or register value
      case (s_q.rd_kind)
         i2csb_pkg::RD_MEM: begin
            s_d.rdata = s_q.rd_err ? i2csb_pkg::INVALID_RD : host_mem_q;
            s_d.rvalid = 1'b1;
         end
         i2csb_pkg::RD_REG: begin
            s_d.rdata = s_q.rd_reg;
            s_d.rvalid = 1'b1;
         end
         default: begin
            s_d.rvalid = 1'b0;
         end
      endcase

      // host writes
      if (host_wr_in && hv) begin
         case (hidx)
            i2csb_pkg::IDX_COUNT: begin
               // table walk: entry 0 is the count, then the lengths
               if (s_q.cfg[hch] == '0) begin
                  s_d.cnt[hch] = (host_wdata_in > i2csb_pkg::MAX_TXN_COUNT) ?
                                 i2csb_pkg::MAX_TXN_COUNT : host_wdata_in;
               end else begin
                  s_d.len[hch][6'(s_q.cfg[hch] - 7'h01)] = host_wdata_in;
               end
               s_d.cfg[hch] = (s_q.cfg[hch] == i2csb_pkg::CFG_LAST) ? '0 :
                              s_q.cfg[hch] + 7'h01;
            end
            i2csb_pkg::IDX_DATA: begin
               // writes while the channel runs are dropped
               if (!chan_active_in[hch] && push_ready) begin
                  if (herr) begin
                     s_d.berr[hch] = 1'b1;
                  end else begin
                     push_valid = 1'b1;
                     push_data = {hch, hptr, host_wdata_in}; // bits kept as given
                  end
                  s_d.ptr[hch] = hptr + 15'h0001;
               end
            end
            i2csb_pkg::IDX_SEL: begin
               s_d.sel[hch] = new_sel;
               s_d.ofs[hch] = i2csb_pkg::OFS_RST;
               s_d.ptr[hch] = base_of(s_q.len[hch], new_sel);
            end
            i2csb_pkg::IDX_OFS: begin
               s_d.ofs[hch] = host_wdata_in;
               s_d.ptr[hch] = base_of(s_q.len[hch], s_q.sel[hch]) +
                              15'(host_wdata_in);
            end
            default: begin
               s_d.cfg[hch] = s_q.cfg[hch]; // byte counter is read-only
            end
         endcase
      end

      // host reads
      if (host_rd_in) begin
         s_d.rd_kind = i2csb_pkg::RD_REG;
         s_d.rd_reg = i2csb_pkg::UNMAPPED_RD;
         if (hv) begin
            case (hidx)
               i2csb_pkg::IDX_COUNT: begin
                  s_d.rd_reg = (s_q.cfg[hch] == '0) ? s_q.cnt[hch] :
                               s_q.len[hch][6'(s_q.cfg[hch] - 7'h01)];
                  s_d.cfg[hch] = (s_q.cfg[hch] == i2csb_pkg::CFG_LAST) ? '0 :
                                 s_q.cfg[hch] + 7'h01;
               end
               i2csb_pkg::IDX_DATA: begin
                  // reads allowed any time; values may be stale mid-sequence
                  s_d.rd_kind = i2csb_pkg::RD_MEM;
                  s_d.rd_err = herr;
                  s_d.berr[hch] = herr;
                  s_d.ptr[hch] = hptr + 15'h0001;
               end
               i2csb_pkg::IDX_SEL: begin
                  s_d.rd_reg = {2'b00, s_q.sel[hch]}; // reserved bits read zero
               end
               i2csb_pkg::IDX_OFS: begin
                  s_d.rd_reg = s_q.ofs[hch];
               end
               default: begin
                  s_d.rd_reg = s_q.bcnt[hch]; // live count
               end
            endcase
         end
      end

      // per-channel rewind, sequence start and go handling
      for (int c = 0; c < i2csb_pkg::NUM_CH; c++) begin
         if (ptr_rewind_in[c]) begin
            // rewind wins over a same-cycle host access to that channel
            s_d.ptr[c] = base_of(s_q.len[c], s_q.sel[c]) + 15'(s_q.ofs[c]);
            s_d.cfg[c] = '0;
         end
         if (!seq_go_in[c]) begin
            s_d.started[c] = 1'b0;
         end else if (!s_q.started[c] && !chan_active_in[c]) begin
            // started latches so one go level gives one start or one clear
            s_d.started[c] = 1'b1;
            if (s_q.cnt[c] == '0) begin
               s_d.go_clr[c] = 1'b1; // no start, no counter change
            end else begin
               s_d.start[c] = 1'b1;
            end
         end
      end

      // byte counter: acked write bytes and every received byte
      if (eng_byte_done_in && (eng_byte_is_read_in || eng_byte_acked_in) &&
          (eng_ch_in != 2'b11)) begin
         if (s_q.bcnt[eng_ch_in] != i2csb_pkg::BYTECNT_MAX) begin
            s_d.bcnt[eng_ch_in] = s_q.bcnt[eng_ch_in] + 8'h01;
         end
      end
      // a start clears the counter, over any same-cycle count
      for (int c = 0; c < i2csb_pkg::NUM_CH; c++) begin
         if (s_d.start[c]) begin
            s_d.bcnt[c] = i2csb_pkg::BYTECNT_RST;
         end
      end

      // transaction info for the engine, one cycle after the index
      s_d.tlen = elen;
      s_d.tinseq = ({2'b00, eng_txn_idx_in} < s_q.cnt[ech]);
      s_d.tlast = ({2'b00, eng_txn_idx_in} == s_q.cnt[ech] - 8'h01);
      // direction comes from the engine's eng_txn_read_in input
      s_d.tskip = !s_d.tinseq || (eng_txn_read_in && elen == '0);
      s_d.taddr_only = s_d.tinseq && !eng_txn_read_in && (elen == '0);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_q <= '0; // select, offset, counts all come up 00h
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // write buffer between the host port and the channel memory
   // ==========================================================================
   // the engine owns the write port when it needs it, so the fifo drains
   // only in its gaps; the host sees back-pressure on the ready pin
   assign drain_ready = !eng_mem_wr_in;
   assign dch = drain_data[i2csb_pkg::FIFO_W-1 -: 2];
   assign dptr = drain_data[i2csb_pkg::FIFO_W-3 -: i2csb_pkg::PTR_W];
   assign dbyte = drain_data[7:0];

   i2csb_fifo #(
      .WIDTH(i2csb_pkg::FIFO_W),
      .DEPTH(i2csb_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .in_valid_in(push_valid),
      .in_ready_out(push_ready),
      .in_data_in(push_data),
      .out_valid_out(drain_valid),
      .out_ready_in(drain_ready),
      .out_data_out(drain_data)
   );

   // ==========================================================================
   // channel buffer memory
   // ==========================================================================
   // no reset on the array; out-of-range engine writes are dropped
   always_ff @(posedge clk_sys_in) begin
      if (eng_mem_wr_in) begin
         if (eng_ch_in != 2'b11 && eng_mem_addr_in < 15'(i2csb_pkg::BUF_DEPTH)) begin
            mem[eng_ch_in][eng_mem_addr_in[12:0]] <= eng_mem_wdata_in;
         end
      end else if (drain_valid) begin
         mem[dch][dptr[12:0]] <= dbyte;
      end
   end

   // read ports; the host byte lands one cycle before the output stage
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         host_mem_q <= 8'h00;
         eng_rdata_q <= 8'h00;
      end else begin
         if (host_rd_in && !herr) begin
            host_mem_q <= mem[mch][hptr[12:0]];
         end
         if (eng_mem_rd_in && eng_ch_in != 2'b11 &&
             eng_mem_addr_in < 15'(i2csb_pkg::BUF_DEPTH)) begin
            eng_rdata_q <= mem[eng_ch_in][eng_mem_addr_in[12:0]];
         end
      end
   end

   // ==========================================================================
   // outputs, all from flops
   // ==========================================================================
   assign host_rdata_out = s_q.rdata;
   assign host_rvalid_out = s_q.rvalid;
   assign host_wr_ready_out = push_ready;
   assign seq_go_clear_out = s_q.go_clr;
   assign seq_start_out = s_q.start;
   assign buf_err_set_out = s_q.berr;
   assign eng_mem_rdata_out = eng_rdata_q;
   assign eng_txn_len_out = s_q.tlen;
   assign eng_txn_skip_out = s_q.tskip;
   assign eng_txn_addr_only_out = s_q.taddr_only;
   assign eng_txn_last_out = s_q.tlast;
   assign eng_txn_in_seq_out = s_q.tinseq;

endmodule

/* testbench/i2csb_seq_cfg_assertions.sv */
// checker of port timing for the sequence buffer config block
`timescale 1ns/1ps
module i2csb_seq_cfg_chk (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic host_rd_in,
   input wire logic host_rvalid_out,
   input wire logic [2:0] seq_go_in,
   input wire logic [2:0] chan_active_in,
   input wire logic [2:0] seq_start_out,
   input wire logic [2:0] seq_go_clear_out,
   input wire logic eng_txn_read_in,
   input wire logic [7:0] eng_txn_len_out,
   input wire logic eng_txn_skip_out,
   input wire logic eng_txn_addr_only_out,
   input wire logic eng_txn_last_out,
   input wire logic eng_txn_in_seq_out
);
   // ==========================================================
   // one clock domain, reset masks every property
   // ==========================================================
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   property p_rd_lat;
      host_rd_in |-> ##2 host_rvalid_out;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_rv_cause;
      host_rvalid_out |-> $past(host_rd_in, 2);
   endproperty
   a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
   property p_start_cause;
      seq_start_out[0] |-> $past(seq_go_in[0]) && !$past(chan_active_in[0]);
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("start w/o go");
   property p_start_excl;
      (seq_start_out & seq_go_clear_out) == 3'h0;
   endproperty
   a_start_excl: assert property (p_start_excl) else $error("start and clear");
   property p_start_pulse;
      seq_start_out[0] |=> !seq_start_out[0];
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start held");
   property p_addr_only;
      eng_txn_addr_only_out |-> eng_txn_in_seq_out && eng_txn_len_out == 8'h00;
   endproperty
   a_addr_only: assert property (p_addr_only) else $error("bad address only");
   property p_rd_skip;
      eng_txn_in_seq_out && eng_txn_len_out == 8'h00 && $past(eng_txn_read_in)
         |-> eng_txn_skip_out;
   endproperty
   a_rd_skip: assert property (p_rd_skip) else $error("empty read not skipped");
   property p_out_seq;
      !eng_txn_in_seq_out && !$past(rst_in) |-> eng_txn_skip_out && !eng_txn_last_out;
   endproperty
   a_out_seq: assert property (p_out_seq) else $error("txn past count runs");
   // main scenarios seen
   c_start: cover property (seq_start_out[0]);
   c_clear: cover property (seq_go_clear_out[2]);
   c_ao: cover property (eng_txn_addr_only_out);
endmodule
bind i2csb_seq_cfg i2csb_seq_cfg_chk chk_u (.*);

/* testbench/i2csb_host_model.sv */
// host cpu model on the parallel register bus
`timescale 1ns/1ps
module i2csb_host_model (
   input wire logic clk_sys_in,
   output logic [7:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] wdata_out,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in
);
   // ==========================================================
   // bus idle at time zero
   // ==========================================================
   initial begin
      addr_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // one-cycle write strobe, taken at the second edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_sys_in);
      wr_out <= 1'b0;
   endtask
   // read; answer unknown if it never comes, so a compare fails
   // caller keeps data reads for idle channels only
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clk_sys_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_sys_in);
      rd_out <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys_in);
         #1;
         if (rvalid_in === 1'b1) begin
            d = rdata_in;
            break;
         end
      end
   endtask
endmodule

/* testbench/i2csb_seq_cfg_bench.sv */
// self-checking bench of the sequence buffer config block
`timescale 1ns/1ps
module i2csb_seq_cfg_bench;
   logic clk_sys_in;
   logic rst_in;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, rvalid, wr_rdy;
   logic [2:0] act, go, rew, go_clr, start, err;
   logic [1:0] ech;
   logic [5:0] eidx;
   logic erd, edone, eack, eisrd, tskip, tao, tlast, tin;
   logic [7:0] tlen, mrdata;
   int fails = 0, tests_run = 0, err_n = 0;
   // ==========================================================
   // clock, error pulse counter
   // ==========================================================
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) if (err[1] === 1'b1) err_n++;
   i2csb_host_model host_u (.clk_sys_in(clk_sys_in), .addr_out(addr), .wr_out(wr),
      .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
   i2csb_seq_cfg dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_addr_in(addr),
      .host_wr_in(wr), .host_rd_in(rd), .host_wdata_in(wdata), .host_rdata_out(rdata),
      .host_rvalid_out(rvalid), .host_wr_ready_out(wr_rdy), .chan_active_in(act),
      .seq_go_in(go), .ptr_rewind_in(rew), .seq_go_clear_out(go_clr),
      .seq_start_out(start), .buf_err_set_out(err), .eng_ch_in(ech),
      .eng_txn_idx_in(eidx), .eng_txn_read_in(erd), .eng_byte_done_in(edone),
      .eng_byte_acked_in(eack), .eng_byte_is_read_in(eisrd), .eng_mem_rd_in(1'b0),
      .eng_mem_wr_in(1'b0), .eng_mem_addr_in(15'h0000), .eng_mem_wdata_in(8'h00),
      .eng_mem_rdata_out(mrdata), .eng_txn_len_out(tlen), .eng_txn_skip_out(tskip),
      .eng_txn_addr_only_out(tao), .eng_txn_last_out(tlast), .eng_txn_in_seq_out(tin));
   // ==========================================================
   // shared helpers
   // ==========================================================
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, d);
      chk(n, {8'h00, e}, {8'h00, d});
   endtask
   task automatic pulse_rew(input int c);
      @(posedge clk_sys_in);
      rew[c] <= 1'b1;
      @(posedge clk_sys_in);
      rew[c] <= 1'b0;
   endtask
   task automatic go_chk(input int c, input logic [2:0] e);
      logic [2:0] seen;
      seen = 3'h0;
      @(posedge clk_sys_in);
      go[c] <= 1'b1;
      repeat (4) begin
         @(posedge clk_sys_in);
         #1;
         seen = seen | {start[c], go_clr[c], 1'b0};
      end
      go[c] <= 1'b0;
      chk("start_clear", {13'h0, e}, {13'h0, seen});
   endtask
   task automatic eq(input logic [5:0] i, input logic r, input logic [11:0] e);
      @(posedge clk_sys_in);
      ech <= 2'd0;
      eidx <= i;
      erd <= r;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("txn_info", {4'h0, e}, {4'h0, tlen, tskip, tao, tlast, tin});
   endtask
   task automatic byte_ev(input logic a, input logic r);
      @(posedge clk_sys_in);
      edone <= 1'b1;
      eack <= a;
      eisrd <= r;
      @(posedge clk_sys_in);
      edone <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_reset();
      rdchk("sel_rst", 8'hc6, 8'h00);
      rdchk("ofs_rst", 8'hc7, 8'h00);
      rdchk("unmapped", 8'h00, 8'h00);
      chk("wr_rdy", 16'h0001, {15'h0, wr_rdy});
      go_chk(2, 3'b010);
      $display("test reset done");
   endtask
   task automatic t_table();
      host_u.wr(8'he4, 8'h50);
      pulse_rew(2);
      rdchk("count_sat", 8'he4, 8'h40);
      pulse_rew(0);
      host_u.wr(8'hc4, 8'h03);
      host_u.wr(8'hc4, 8'h02);
      host_u.wr(8'hc4, 8'h00);
      host_u.wr(8'hc4, 8'h01);
      eq(6'd0, 1'b0, 12'h021);
      eq(6'd1, 1'b1, 12'h009);
      eq(6'd1, 1'b0, 12'h005);
      eq(6'd2, 1'b0, 12'h013);
      eq(6'd3, 1'b0, 12'h008);
      $display("test table done");
   endtask
   task automatic t_data();
      host_u.wr(8'hc6, 8'h00);
      host_u.wr(8'hc5, 8'ha1);
      host_u.wr(8'hc5, 8'hb2);
      host_u.wr(8'hc5, 8'hc3);
      repeat (12) @(posedge clk_sys_in); // fifo drain time
      host_u.wr(8'hc7, 8'h01);
      host_u.wr(8'hc6, 8'h02);
      rdchk("ofs_clr", 8'hc7, 8'h00);
      rdchk("next_txn", 8'hc5, 8'hc3);
      pulse_rew(0);
      rdchk("rewind", 8'hc5, 8'hc3);
      @(posedge clk_sys_in);
      act[0] <= 1'b1;
      host_u.wr(8'hc6, 8'h00);
      host_u.wr(8'hc5, 8'hee);
      @(posedge clk_sys_in);
      act[0] <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
      host_u.wr(8'hc6, 8'h00);
      rdchk("busy_wr", 8'hc5, 8'ha1);
      rdchk("auto_inc", 8'hc5, 8'hb2);
      $display("test data done");
   endtask
   task automatic t_error();
      int n0;
      pulse_rew(1);
      for (int i = 0; i < 65; i++) host_u.wr(8'hd4, (i == 0) ? 8'h40 : 8'hff);
      host_u.wr(8'hd6, 8'h51);
      rdchk("sel_bits", 8'hd6, 8'h11);
      host_u.wr(8'hd7, 8'h10);
      n0 = err_n;
      host_u.rd(8'hd5, d);
      chk("in_buf", 16'h0000, 16'(err_n - n0));
      host_u.wr(8'hd7, 8'h11);
      rdchk("ofs_out", 8'hd5, 8'h00);
      host_u.wr(8'hd6, 8'h3f);
      rdchk("sel_out", 8'hd5, 8'h00);
      chk("err_cnt", 16'h0002, 16'(err_n - n0));
      $display("test error done");
   endtask
   task automatic t_seq();
      @(posedge clk_sys_in);
      ech <= 2'd0;
      byte_ev(1'b1, 1'b0);
      go_chk(0, 3'b100);
      rdchk("cnt_clr", 8'hc8, 8'h00);
      byte_ev(1'b1, 1'b0);
      byte_ev(1'b0, 1'b0);
      byte_ev(1'b0, 1'b1);
      host_u.wr(8'hc8, 8'h55);
      rdchk("bytecnt", 8'hc8, 8'h02);
      $display("test sequence done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   // ==========================================================
   initial begin
      rst_in = 1'b1;
      {act, go, rew} = 9'h000;
      ech = 2'd3;
      eidx = 6'h00;
      {erd, edone, eack, eisrd} = 4'h0;
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      t_reset();
      t_table();
      t_data();
      t_error();
      t_seq();
      give_verdict();
   end
   initial begin
      #400000;
      fails++;
      give_verdict();
   end
endmodule
